// ==== hw/adc_sequencer_control.sv ====
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module adc_sequencer_control (
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst,
   // Straps
   input  wire logic                      portbAnalogDefault,
   input  wire logic                      largePackage,
   // Register port
   input  wire logic [2:0]                address,
   input  wire logic [7:0]                writeData,
   input  wire logic                      writeStrobe,
   input  wire logic                      readStrobe,
   output logic      [7:0]                readData,
   // Analog side
   input  wire logic                      comparatorHigh,
   input  wire logic                      rcTick,
   output adc_seq_pkg::analog_ctrl_t      analogCtrl,
   output logic      [9:0]                dacTrial,
   output logic      [12:0]               analogPinMask,
   // Status
   output logic                           conversionDoneFlag
);

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic [3:0]  channelSelect_r;
   logic        converterOn_r;
   logic        goBusy_r;
   logic        negRefSelect_r;
   logic        posRefSelect_r;
   logic [3:0]  pinAnalogConfig_r;
   logic        resultJustify_r;
   logic [2:0]  acquisitionLength_r;
   logic [2:0]  conversionClockSelect_r;
   logic [7:0]  resultHighByte_r;
   logic [7:0]  resultLowByte_r;
   logic        doneFlag_r;
   logic        largePackage_r;
   logic [7:0]  readData_r;
   adc_seq_pkg::analog_ctrl_t analogCtrl_r;
   logic [12:0] analogPinMask_r;

   adc_seq_pkg::conv_state_t state_r;
   logic [4:0]  tadCount_r;
   logic [2:0]  rcDelay_r;
   logic [9:0]  sar_r;

   logic        wrMain;
   logic        startReq;
   logic        tadTick;
   logic        tickRun;
   logic        rcSelected;
   logic        convDone;
   logic [4:0]  acqLen;
   logic [3:0]  bitPos;
   logic [9:0]  sarFinal;
   logic [12:0] maskNxt;
   logic        chanValidNxt;

   assign wrMain     = writeStrobe && (address == adc_seq_pkg::OFF_MAIN_CONTROL);
   assign startReq   = wrMain && writeData[adc_seq_pkg::BIT_GO_BUSY]
                       && writeData[adc_seq_pkg::BIT_CONVERTER_ON]
                       && !goBusy_r;
   assign rcSelected = (conversionClockSelect_r[1:0] == 2'h3);
   assign acqLen     = adc_seq_pkg::acq_tads(acquisitionLength_r);
   assign tickRun    = (state_r == adc_seq_pkg::ST_ACQUIRE)
                       || (state_r == adc_seq_pkg::ST_CONVERT);
   assign bitPos     = 4'(adc_seq_pkg::CONV_TADS - tadCount_r - 5'h01);
   assign convDone   = (state_r == adc_seq_pkg::ST_CONVERT) && tadTick && converterOn_r && !rst
                       && (tadCount_r == adc_seq_pkg::CONV_TADS - 5'h01);

   // ***************************************************************
   // Conversion clock
   // ***************************************************************
   adc_tad_tick tadGen (
      .clock       (clock),
      .rst         (rst),
      .run         (tickRun),
      .clockSelect (conversionClockSelect_r),
      .rcTick      (rcTick),
      .tadTick     (tadTick)
   );

   // ***************************************************************
   // Control registers
   // ***************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         channelSelect_r <= adc_seq_pkg::RST_MAIN_CONTROL[adc_seq_pkg::CHAN_MSB:
                                                          adc_seq_pkg::CHAN_LSB];
         converterOn_r   <= adc_seq_pkg::RST_MAIN_CONTROL[adc_seq_pkg::BIT_CONVERTER_ON];
      end else if (wrMain) begin
         channelSelect_r <= writeData[adc_seq_pkg::CHAN_MSB:adc_seq_pkg::CHAN_LSB];
         converterOn_r   <= writeData[adc_seq_pkg::BIT_CONVERTER_ON];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         {negRefSelect_r, posRefSelect_r} <= adc_seq_pkg::RST_REF_BITS;
         pinAnalogConfig_r[adc_seq_pkg::PCFG_MSB] <= adc_seq_pkg::RST_PCFG_MSB;
         pinAnalogConfig_r[2:0] <= portbAnalogDefault ? adc_seq_pkg::PCFG_LOW_ANALOG
                                                      : adc_seq_pkg::PCFG_LOW_DIGITAL;
      end else if (writeStrobe && address == adc_seq_pkg::OFF_PIN_REF_CFG) begin
         negRefSelect_r    <= writeData[adc_seq_pkg::BIT_NEG_REF];
         posRefSelect_r    <= writeData[adc_seq_pkg::BIT_POS_REF];
         pinAnalogConfig_r <= writeData[adc_seq_pkg::PCFG_MSB:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         resultJustify_r         <= adc_seq_pkg::RST_TIMING_FMT[adc_seq_pkg::BIT_JUSTIFY];
         acquisitionLength_r     <= adc_seq_pkg::RST_TIMING_FMT[adc_seq_pkg::ACQ_MSB:
                                                               adc_seq_pkg::ACQ_LSB];
         conversionClockSelect_r <= adc_seq_pkg::RST_TIMING_FMT[adc_seq_pkg::CLKSEL_MSB:0];
      end else if (writeStrobe && address == adc_seq_pkg::OFF_TIMING_FMT) begin
         resultJustify_r         <= writeData[adc_seq_pkg::BIT_JUSTIFY];
         acquisitionLength_r     <= writeData[adc_seq_pkg::ACQ_MSB:adc_seq_pkg::ACQ_LSB];
         conversionClockSelect_r <= writeData[adc_seq_pkg::CLKSEL_MSB:0];
      end
   end

   // Package strap caught on every clocked reset cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         largePackage_r <= largePackage;
      end
   end

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   always_ff @(posedge clock) begin
      if (rst || !converterOn_r) begin
         state_r    <= adc_seq_pkg::ST_SAMPLE;
         goBusy_r   <= 1'b0;
         tadCount_r <= 5'h00;
         rcDelay_r  <= 3'h0;
         sar_r      <= 10'h000;
      end else begin
         case (state_r)
            adc_seq_pkg::ST_SAMPLE: begin
               if (startReq) begin
                  goBusy_r   <= 1'b1;
                  tadCount_r <= 5'h00;
                  rcDelay_r  <= 3'h0;
                  if (rcSelected) begin
                     state_r <= adc_seq_pkg::ST_RCDELAY;
                  end else if (acqLen != 5'h00) begin
                     state_r <= adc_seq_pkg::ST_ACQUIRE;
                  end else begin
                     state_r <= adc_seq_pkg::ST_CONVERT;
                  end
               end
            end
            adc_seq_pkg::ST_RCDELAY: begin
               if (rcDelay_r == adc_seq_pkg::INSTR_CYCLE_CYCLES - 3'h1) begin
                  state_r <= (acqLen != 5'h00) ? adc_seq_pkg::ST_ACQUIRE
                                               : adc_seq_pkg::ST_CONVERT;
               end else begin
                  rcDelay_r <= rcDelay_r + 3'h1;
               end
            end
            adc_seq_pkg::ST_ACQUIRE: begin
               if (tadTick) begin
                  if (tadCount_r == acqLen - 5'h01) begin
                     tadCount_r <= 5'h00;
                     state_r    <= adc_seq_pkg::ST_CONVERT;
                  end else begin
                     tadCount_r <= tadCount_r + 5'h01;
                  end
               end
            end
            adc_seq_pkg::ST_CONVERT: begin
               if (tadTick) begin
                  if (tadCount_r == 5'h00) begin
                     sar_r <= adc_seq_pkg::SAR_FIRST_TRIAL;
                  end else begin
                     sar_r <= sarFinal;
                  end
                  if (convDone) begin
                     goBusy_r   <= 1'b0;
                     tadCount_r <= 5'h00;
                     state_r    <= adc_seq_pkg::ST_SAMPLE;
                  end else begin
                     tadCount_r <= tadCount_r + 5'h01;
                  end
               end
            end
            default: begin
               state_r  <= adc_seq_pkg::ST_SAMPLE;
               goBusy_r <= 1'b0;
            end
         endcase
      end
   end

   // Keep or drop the bit under trial, then set the next trial bit
   always_comb begin
      sarFinal = sar_r;
      if (tadCount_r != 5'h00) begin
         sarFinal[bitPos] = comparatorHigh;
         if (bitPos != 4'h0) begin
            sarFinal[bitPos - 4'h1] = 1'b1;
         end
      end
   end

   // ***************************************************************
   // Result pair, no reset
   // ***************************************************************
   always_ff @(posedge clock) begin
      if (convDone) begin
         if (resultJustify_r) begin
            resultHighByte_r <= {6'h00, sarFinal[9:8]};
            resultLowByte_r  <= sarFinal[7:0];
         end else begin
            resultHighByte_r <= sarFinal[9:2];
            resultLowByte_r  <= {sarFinal[1:0], 6'h00};
         end
      end
   end

   // Completion flag: a completion in the clearing cycle wins
   always_ff @(posedge clock) begin
      if (rst) begin
         doneFlag_r <= 1'b0;
      end else if (convDone) begin
         doneFlag_r <= 1'b1;
      end else if (writeStrobe && address == adc_seq_pkg::OFF_STATUS) begin
         doneFlag_r <= writeData[adc_seq_pkg::BIT_DONE_FLAG];
      end
   end

   // ***************************************************************
   // Analog side
   // ***************************************************************
   always_comb begin
      for (int i = 0; i < adc_seq_pkg::NUM_INPUTS; i++) begin
         maskNxt[i] = (5'(i) + {1'b0, pinAnalogConfig_r} < 5'h0f)
                      && (largePackage_r || 4'(i) < adc_seq_pkg::SMALL_GAP_FIRST
                          || 4'(i) > adc_seq_pkg::SMALL_GAP_LAST);
      end
      chanValidNxt = (channelSelect_r <= adc_seq_pkg::LAST_CHANNEL)
                     && (largePackage_r
                         || channelSelect_r < adc_seq_pkg::SMALL_GAP_FIRST
                         || channelSelect_r > adc_seq_pkg::SMALL_GAP_LAST);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         analogCtrl_r    <= '0;
         analogPinMask_r <= 13'h0000;
      end else begin
         analogCtrl_r.channel         <= channelSelect_r;
         analogCtrl_r.channelValid    <= chanValidNxt;
         analogCtrl_r.negRefFromInput <= negRefSelect_r;
         analogCtrl_r.posRefFromInput <= posRefSelect_r;
         analogCtrl_r.sampleOn        <= converterOn_r
                                         && state_r != adc_seq_pkg::ST_CONVERT;
         analogPinMask_r              <= maskNxt;
      end
   end

   // ***************************************************************
   // Register read port
   // ***************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         readData_r <= 8'h00;
      end else if (readStrobe) begin
         case (address)
            adc_seq_pkg::OFF_MAIN_CONTROL:
               readData_r <= {2'h0, channelSelect_r,
                              goBusy_r && converterOn_r, converterOn_r};
            adc_seq_pkg::OFF_PIN_REF_CFG:
               readData_r <= {2'h0, negRefSelect_r, posRefSelect_r, pinAnalogConfig_r};
            adc_seq_pkg::OFF_TIMING_FMT:
               readData_r <= {resultJustify_r, 1'b0, acquisitionLength_r,
                              conversionClockSelect_r};
            adc_seq_pkg::OFF_RESULT_HIGH: readData_r <= resultHighByte_r;
            adc_seq_pkg::OFF_RESULT_LOW:  readData_r <= resultLowByte_r;
            adc_seq_pkg::OFF_STATUS:      readData_r <= {7'h00, doneFlag_r};
            default:                      readData_r <= 8'h00;
         endcase
      end else begin
         readData_r <= 8'h00;
      end
   end

   assign readData           = readData_r;
   assign analogCtrl         = analogCtrl_r;
   assign dacTrial           = sar_r;
   assign analogPinMask      = analogPinMask_r;
   assign conversionDoneFlag = doneFlag_r;

endmodule : adc_sequencer_control

// ==== hw/adc_seq_pkg.sv ====
package adc_seq_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [2:0] OFF_MAIN_CONTROL = 3'h0;
   localparam logic [2:0] OFF_PIN_REF_CFG  = 3'h1;
   localparam logic [2:0] OFF_TIMING_FMT   = 3'h2;
   localparam logic [2:0] OFF_RESULT_HIGH  = 3'h3;
   localparam logic [2:0] OFF_RESULT_LOW   = 3'h4;
   localparam logic [2:0] OFF_STATUS       = 3'h5;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int BIT_CONVERTER_ON = 0;
   localparam int BIT_GO_BUSY      = 1;
   localparam int CHAN_LSB         = 2;
   localparam int CHAN_MSB         = 5;
   localparam int BIT_NEG_REF      = 5;
   localparam int BIT_POS_REF      = 4;
   localparam int PCFG_MSB         = 3;
   localparam int BIT_JUSTIFY      = 7;
   localparam int ACQ_LSB          = 3;
   localparam int ACQ_MSB          = 5;
   localparam int CLKSEL_MSB       = 2;
   localparam int BIT_DONE_FLAG    = 0;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
   localparam logic [7:0] RST_TIMING_FMT   = 8'h00;
   localparam logic [1:0] RST_REF_BITS     = 2'h0;
   localparam logic       RST_PCFG_MSB     = 1'h0;
   localparam logic [2:0] PCFG_LOW_ANALOG  = 3'h0;
   localparam logic [2:0] PCFG_LOW_DIGITAL = 3'h7;

   // ***************************************************************
   // Channels and conversion
   // ***************************************************************
   localparam int         NUM_INPUTS      = 13;
   localparam logic [3:0] LAST_CHANNEL    = 4'hc;
   localparam logic [3:0] SMALL_GAP_FIRST = 4'h5;
   localparam logic [3:0] SMALL_GAP_LAST  = 4'h7;
   localparam int         RESULT_BITS     = 10;
   localparam logic [4:0] CONV_TADS       = 5'h0b;
   localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLOCK_PERIOD_NS     = 100;
   localparam int INSTR_CYCLE_NS      = 400;
   localparam int INSTR_CYCLE_CYCLES_I =
      (INSTR_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic [2:0] INSTR_CYCLE_CYCLES = 3'(INSTR_CYCLE_CYCLES_I);

   // Conversion clock select codes
   localparam logic [2:0] CLK_DIV2  = 3'h0;
   localparam logic [2:0] CLK_DIV8  = 3'h1;
   localparam logic [2:0] CLK_DIV32 = 3'h2;
   localparam logic [2:0] CLK_DIV4  = 3'h4;
   localparam logic [2:0] CLK_DIV16 = 3'h5;
   localparam logic [2:0] CLK_DIV64 = 3'h6;

   typedef enum logic [3:0] {
      ST_SAMPLE  = 4'h1,
      ST_RCDELAY = 4'h2,
      ST_ACQUIRE = 4'h4,
      ST_CONVERT = 4'h8
   } conv_state_t;

   typedef struct packed {
      logic [3:0] channel;
      logic       channelValid;
      logic       negRefFromInput;
      logic       posRefFromInput;
      logic       sampleOn;
   } analog_ctrl_t;

   function automatic logic [4:0] acq_tads(input logic [2:0] code);
      case (code)
         3'h7:    acq_tads = 5'h14;
         3'h6:    acq_tads = 5'h10;
         3'h5:    acq_tads = 5'h0c;
         3'h4:    acq_tads = 5'h08;
         3'h3:    acq_tads = 5'h06;
         3'h2:    acq_tads = 5'h04;
         3'h1:    acq_tads = 5'h02;
         default: acq_tads = 5'h00;
      endcase
   endfunction : acq_tads

   function automatic logic [6:0] div_cycles(input logic [2:0] code);
      case (code)
         CLK_DIV2:  div_cycles = 7'h02;
         CLK_DIV8:  div_cycles = 7'h08;
         CLK_DIV32: div_cycles = 7'h20;
         CLK_DIV4:  div_cycles = 7'h04;
         CLK_DIV16: div_cycles = 7'h10;
         CLK_DIV64: div_cycles = 7'h40;
         default:   div_cycles = 7'h02;
      endcase
   endfunction : div_cycles

endpackage : adc_seq_pkg

// ==== hw/adc_tad_tick.sv ====
`timescale 1ns/1ps
module adc_tad_tick (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] clockSelect,
   input  wire logic       rcTick,
   // Conversion bit period strobe
   output logic            tadTick
);

   logic [6:0] divCount_r;
   logic       useRc;

   assign useRc = (clockSelect[1:0] == 2'h3);

   // ***************************************************************
   // Oscillator divider or internal RC pulse
   // ***************************************************************
   always_ff @(posedge clock) begin
      if (rst || !run || useRc) begin
         divCount_r <= 7'h00;
      end else if (divCount_r == adc_seq_pkg::div_cycles(clockSelect) - 7'h01) begin
         divCount_r <= 7'h00;
      end else begin
         divCount_r <= divCount_r + 7'h01;
      end
   end

   always_comb begin
      if (!run) begin
         tadTick = 1'b0;
      end else if (useRc) begin
         tadTick = rcTick;
      end else begin
         tadTick = (divCount_r == adc_seq_pkg::div_cycles(clockSelect) - 7'h01);
      end
   end

endmodule : adc_tad_tick

// ==== verif/adc_seq_chk.sv ====
`timescale 1ns/1ps
module adc_seq_chk (
   // Clock and reset
   input wire logic                      clock,
   input wire logic                      rst,
   // Register port and strap
   input wire logic                      largePackage,
   input wire logic [2:0]                address,
   input wire logic [7:0]                writeData,
   input wire logic                      writeStrobe,
   input wire logic                      readStrobe,
   input wire logic [7:0]                readData,
   // Watched outputs
   input wire adc_seq_pkg::analog_ctrl_t analogCtrl,
   input wire logic [12:0]               analogPinMask,
   input wire logic                      conversionDoneFlag
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Config write followed by a quiet cycle
   sequence cfg_settle;
      (writeStrobe && address == 3'h1) ##1 !(writeStrobe && address == 3'h1);
   endsequence
   a_main_top_zero: assert property (readStrobe && address == 3'h0 |=> readData[7:6] == 2'h0)
      else $error("main control upper bits set");
   a_neg_ref_sel: assert property (cfg_settle |=> analogCtrl.negRefFromInput == $past(writeData[5], 2))
      else $error("negative reference select wrong");
   a_pos_ref_sel: assert property (cfg_settle |=> analogCtrl.posRefFromInput == $past(writeData[4], 2))
      else $error("positive reference select wrong");
   a_all_digital: assert property (cfg_settle |=> ($past(writeData[3:0], 2) == 4'hf) == (analogPinMask == 13'h0000))
      else $error("pin mask all-digital decode wrong");
   a_chan_range: assert property (analogCtrl.channelValid |-> analogCtrl.channel <= 4'hc)
      else $error("unimplemented channel marked valid");
   a_gap_invalid: assert property (!largePackage && analogCtrl.channel inside {[4'h5:4'h7]} |-> !analogCtrl.channelValid)
      else $error("absent channel marked valid");
   a_resume_sample: assert property ($rose(conversionDoneFlag) |-> ##[0:2] analogCtrl.sampleOn)
      else $error("sampling not resumed after completion");
   a_flag_sticky: assert property (conversionDoneFlag && !(writeStrobe && address == 3'h5) ##1 !(writeStrobe && address == 3'h5) |=> conversionDoneFlag)
      else $error("completion flag dropped without clear");
endmodule : adc_seq_chk

// ==== verif/analog_model.sv ====
`timescale 1ns/1ps
module analog_model (
   // Clock
   input  wire logic                      clock,
   // Converter side
   input  wire adc_seq_pkg::analog_ctrl_t analogCtrl,
   input  wire logic [9:0]                dacTrial,
   input  wire logic [129:0]              levels,
   output logic                           comparatorHigh,
   output logic                           rcTick
);
   logic [9:0] held = 10'h000;
   logic [2:0] rcCnt = 3'h0;
   logic       noise = 1'b0;
   always @(posedge clock) begin
      if (analogCtrl.sampleOn && analogCtrl.channelValid) held <= levels[analogCtrl.channel*10 +: 10];
      rcCnt <= (rcCnt == 3'h4) ? 3'h0 : rcCnt + 3'h1;
      noise <= ~noise;
   end
   assign rcTick = (rcCnt == 3'h0);
   // Absent channel floats: comparator toggles every cycle
   assign comparatorHigh = analogCtrl.channelValid ? (held >= dacTrial) : noise;
endmodule : analog_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
   logic                      clock = 1'b0;
   logic                      rst = 1'b1;
   logic                      portbAnalogDefault = 1'b0;
   logic                      largePackage = 1'b0;
   logic [2:0]                address = 3'h0;
   logic [7:0]                writeData = 8'h00;
   logic                      writeStrobe = 1'b0;
   logic                      readStrobe = 1'b0;
   logic [7:0]                readData;
   logic                      comparatorHigh;
   logic                      rcTick;
   adc_seq_pkg::analog_ctrl_t analogCtrl;
   logic [9:0]                dacTrial;
   logic [12:0]               analogPinMask;
   logic                      conversionDoneFlag;
   logic [129:0]              levels;
   int                        error_cnt = 0;
   int                        samples_checked = 0;
   int                        divs[8] = '{2, 8, 32, 5, 4, 16, 64, 5};
   int                        acqs[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   always #50 clock = ~clock;
   initial for (int k = 0; k < 13; k++) levels[k*10 +: 10] = 10'(k * 71 + 13);
   adc_sequencer_control u_adc_sequencer_control (
      .clock(clock), .rst(rst), .portbAnalogDefault(portbAnalogDefault),
      .largePackage(largePackage),
      .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
      .readStrobe(readStrobe), .readData(readData), .comparatorHigh(comparatorHigh),
      .rcTick(rcTick), .analogCtrl(analogCtrl), .dacTrial(dacTrial),
      .analogPinMask(analogPinMask), .conversionDoneFlag(conversionDoneFlag));
   analog_model u_analog_model (
      .clock(clock), .analogCtrl(analogCtrl), .dacTrial(dacTrial), .levels(levels),
      .comparatorHigh(comparatorHigh), .rcTick(rcTick));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic span(input int n, input int lo, input int hi);
      samples_checked++;
      if (n < lo || n > hi) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
      end
   endtask : span
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      address <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clock);
      writeStrobe <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rdc(input logic [2:0] a, input logic [7:0] e);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
      #1 cmp(readData, e);
      @(posedge clock);
   endtask : rdc
   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      #4000000;
      error_cnt++;
      complete_run();
   end
   initial begin
      logic [3:0] ch;
      logic [9:0] lv;
      logic [7:0] hv;
      int         n;
      int         x;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rdc(3'h0, 8'h00);
      rdc(3'h1, 8'h07);
      rdc(3'h2, 8'h00);
      cmp(analogPinMask, 13'h001f);
      wr(3'h6, 8'hff);
      rdc(3'h6, 8'h00);
      for (int c = 0; c < 16; c++) begin
         wr(3'h1, {2'h3, 2'(c), 4'(c)});
         rdc(3'h1, {2'h0, 2'(c), 4'(c)});
         cmp(analogCtrl.negRefFromInput, c[1]);
         cmp(analogCtrl.posRefFromInput, c[0]);
         cmp(analogPinMask, (c < 3 ? 13'h1fff : 13'h1fff >> (c - 2)) & 13'h1f1f);
      end
      wr(3'h0, 8'hc2);
      rdc(3'h0, 8'h00);
      repeat (60) @(posedge clock);
      #1 cmp(conversionDoneFlag, 1'b0);
      $display("test config done");
      for (int i = 0; i < 8; i++) begin
         ch = (i < 5) ? 4'(i) : 4'(i + 3);
         lv = levels[ch*10 +: 10];
         wr(3'h2, {i[0], 1'b0, 3'(7 - i), 3'(i)});
         wr(3'h5, 8'h00);
         wr(3'h0, {2'h0, ch, 2'h1});
         wr(3'h0, {2'h0, ch, 2'h3});
         n = 1;
         while (conversionDoneFlag !== 1'b1 && n < 3000) begin
            @(posedge clock);
            #1 n++;
         end
         x = (acqs[7-i] + 11) * divs[i];
         span(n, x, x + 4);
         rdc(3'h0, {2'h0, ch, 2'h1});
         rdc(3'h5, 8'h01);
         hv = i[0] ? {6'h0, lv[9:8]} : lv[9:2];
         rdc(3'h3, hv);
         rdc(3'h4, i[0] ? lv[7:0] : {lv[1:0], 6'h0});
         repeat (130) @(posedge clock);
      end
      $display("test conversions done");
      wr(3'h2, 8'h3e);
      wr(3'h0, 8'h19);
      wr(3'h0, 8'h1b);
      repeat (50) @(posedge clock);
      rdc(3'h0, 8'h1b);
      wr(3'h5, 8'h00);
      wr(3'h0, 8'h18);
      rdc(3'h0, 8'h18);
      repeat (2500) @(posedge clock);
      rdc(3'h5, 8'h00);
      rdc(3'h3, hv);
      $display("test abort done");
      wr(3'h0, 8'h19);
      wr(3'h0, 8'h1b);
      repeat (20) @(posedge clock);
      portbAnalogDefault <= 1'b1;
      largePackage <= 1'b1;
      rst <= 1'b1;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rdc(3'h0, 8'h00);
      rdc(3'h2, 8'h00);
      rdc(3'h5, 8'h00);
      rdc(3'h1, 8'h00);
      rdc(3'h3, hv);
      cmp(analogPinMask, 13'h1fff);
      $display("test reset done");
      complete_run();
   end
endmodule : tb
bind adc_sequencer_control adc_seq_chk u_adc_seq_chk (
   .clock(clock), .rst(rst), .largePackage(largePackage), .address(address),
   .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
   .readData(readData), .analogCtrl(analogCtrl), .analogPinMask(analogPinMask),
   .conversionDoneFlag(conversionDoneFlag));
